// ### logic/kp_pkg.sv
/*
  Constants, types and register map of the panel keypad programmer.
  Assumes a 20 MHz system clock and AXI4-Lite register access.
*/
package kp_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ   = 20_000_000;
  localparam int unsigned HOLD_MS  = 10_000;
  localparam int unsigned RPT_MS   = 400;
  localparam int unsigned SCRL_MS  = 1_000;
  localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned RPT_CYC  = RPT_MS * (CLK_HZ / 1000);
  localparam int unsigned SCRL_CYC = SCRL_MS * (CLK_HZ / 1000);
  localparam int          CNT_W    = 28;

  // ==========================================================
  // Values, four BCD digits dd.dd
  localparam int                VAL_W       = 16;
  localparam logic [15:0]       PRESET1_RST = 16'h0500;
  localparam logic [15:0]       PRESET2_RST = 16'h1000;
  localparam logic [1:0][15:0]  PRESET_RST  = {PRESET2_RST, PRESET1_RST};
  localparam logic [15:0]       TOUT_RST    = 16'h0010;
  localparam logic [15:0]       TOUT_ZERO   = 16'h0000;
  localparam logic [15:0]       ST_PATTERN  = 16'h8888;
  localparam logic [3:0]        DIG_MAX     = 4'h9;
  localparam int                SCRL_LAST   = 4;

  // ==========================================================
  // Register map
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STAT     = 8'h04;
  localparam logic [7:0]  REG_PRE1     = 8'h08;
  localparam logic [7:0]  REG_PRE2     = 8'h0c;
  localparam logic [7:0]  REG_TOUT1    = 8'h10;
  localparam logic [7:0]  REG_TOUT2    = 8'h14;
  localparam int          CTRL_RTP_BIT = 0;
  localparam logic        CTRL_RST     = 1'b0;
  localparam int          STAT_ST_LSB  = 0;
  localparam int          STAT_SCRL    = 2;
  localparam int          STAT_DIRTY   = 3;
  localparam int          STAT_PEND    = 4;
  localparam int          STAT_ACT     = 6;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {KP_NORMAL, KP_PRESET, KP_TOUT, KP_SELFTEST} kp_state_e;
  typedef enum logic [1:0] {LBL_NONE, LBL_P1, LBL_P2} kp_label_e;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } kp_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } kp_axi_rsp_s;

  typedef struct packed {
    logic [3:0] digit;
    logic       reset;
    logic       p1;
    logic       p2;
    logic       enter;
  } kp_keys_s;

  typedef struct packed {
    logic             wr;
    logic             ch;
    logic             kind;
    logic [VAL_W-1:0] data;
  } kp_nv_s;
endpackage : kp_pkg

// ### logic/kp_axil.sv
/*
  AXI4-Lite slave front end of the keypad programmer.
  Assumes the parent decodes addresses and supplies read data combinationally.
*/
module kp_axil (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire kp_pkg::kp_axi_req_s         axi_req,
  output      kp_pkg::kp_axi_rsp_s         axi_rsp,
  output      logic                        wr_en,
  output      logic [kp_pkg::ADDR_W-1:0]   wr_addr,
  output      logic [31:0]                 wr_data,
  output      logic [3:0]                  wr_strb,
  input  wire logic                        wr_ok,
  output      logic [kp_pkg::ADDR_W-1:0]   rd_addr,
  input  wire logic [31:0]                 rd_data,
  input  wire logic                        rd_ok
);
  import kp_pkg::*;

  logic              aw_q, w_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q, rdata_q;
  logic [3:0]        wstrb_q;
  logic [1:0]        bresp_q, rresp_q;

  // Write fires once both halves are held and the last answer is gone
  assign wr_en   = aw_q & w_q & ~bvalid_q;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;
  assign rd_addr = axi_req.araddr;

  always_ff @(posedge clk) begin
    if (!rst_b || wr_en) begin
      aw_q <= 1'b0;
    end else if (axi_req.awvalid && !aw_q) begin
      aw_q     <= 1'b1;
      awaddr_q <= axi_req.awaddr;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || wr_en) begin
      w_q <= 1'b0;
    end else if (axi_req.wvalid && !w_q) begin
      w_q     <= 1'b1;
      wdata_q <= axi_req.wdata;
      wstrb_q <= axi_req.wstrb;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (rvalid_q) begin
      if (axi_req.rready) rvalid_q <= 1'b0;
    end else if (axi_req.arvalid) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_ok ? rd_data : '0;
      rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  assign axi_rsp = '{awready: ~aw_q, wready: ~w_q, bvalid: bvalid_q, bresp: bresp_q,
                     arready: ~rvalid_q, rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};
endmodule : kp_axil

// ### logic/kp_panel.sv
/*
  Front-panel keypad programmer of a preset timer: key decoding, preset and
  timed-output viewing and editing, display selection, scrolling, self-test exit.
  Assumes keys and switches are debounced and synchronous to clk, and that the
  timing core acts on timer_reset and on the applied values it is given.
*/
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
module kp_panel #(
  parameter bit          DUAL     = 1'b1,
  parameter int unsigned HOLD_CYC = kp_pkg::HOLD_CYC,
  parameter int unsigned RPT_CYC  = kp_pkg::RPT_CYC,
  parameter int unsigned SCRL_CYC = kp_pkg::SCRL_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire kp_pkg::kp_axi_req_s      axi_req,
  output      kp_pkg::kp_axi_rsp_s      axi_rsp,
  input  wire kp_pkg::kp_keys_s         keys,
  input  wire logic                     reset_enable_switch,
  input  wire logic                     program_lock_input_b,
  input  wire logic [15:0]              run_time,
  input  wire logic [1:0]               out_active,
  output      logic                     timer_reset,
  output      logic                     timer_to_preset,
  output      logic                     outputs_off,
  output      logic [1:0][15:0]         preset_val,
  output      logic [1:0][15:0]         tout_val,
  output      logic [15:0]              disp_value,
  output      kp_pkg::kp_label_e        disp_label,
  output      kp_pkg::kp_nv_s           nv_write,
  output      logic [1:0]               test_out
);
  import kp_pkg::*;

  // ==========================================================
  // Declarations
  kp_state_e             st_q;
  kp_keys_s              key_q, rise;
  kp_label_e             disp_label_q;
  kp_nv_s                nv_q;
  logic                  sel_q, dirty_q, scrl_q, ctrl_rtp_q;
  logic                  timer_reset_q, outputs_off_q;
  logic [1:0]            pend_q, test_q;
  logic [15:0]           edit_q, edit_inc, disp_value_q;
  logic [1:0][15:0]      preset_q, tout_sto_q, tout_q;
  logic [CNT_W-1:0]      tmo_q, rpt_q, scrl_cnt_q;
  logic [2:0]            scrl_idx_q;
  logic [3:0]            inc;
  logic                  any_ev, rst_press, tout_entry, do_reset, unlocked;
  logic                  edit_mode, rpt_fire, store_ok, p2_ok;
  logic                  wr_en, wr_ok, rd_ok;
  logic [ADDR_W-1:0]     wr_addr, rd_addr;
  logic [31:0]           wr_data, rd_data;
  logic [3:0]            wr_strb;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // Key events
  always_ff @(posedge clk) begin
    if (!rst_b) key_q <= '0;
    else key_q <= keys;
  end

  assign rise       = keys & ~key_q;
  assign any_ev     = keys != key_q;
  assign unlocked   = program_lock_input_b;
  assign p2_ok      = DUAL & keys.p2;
  assign rst_press  = rise.reset & reset_enable_switch;
  // Outside self-test, reset with a preset key held opens the duration view instead
  assign tout_entry = rst_press & (keys.p1 | p2_ok) & (st_q != KP_SELFTEST);
  assign do_reset   = rst_press & ~tout_entry;
  assign edit_mode  = (st_q == KP_PRESET) || (st_q == KP_TOUT);
  // A zero duration is outside the accepted range and is never stored
  assign store_ok   = edit_mode & rise.enter & dirty_q & unlocked & ~rst_press
                      & ~((st_q == KP_TOUT) && (edit_q == TOUT_ZERO));

  // ==========================================================
  // Inactivity and auto-repeat timers
  always_ff @(posedge clk) begin
    // Held keys keep the view open; the ten seconds run from the last release
    if (!rst_b || any_ev || (|keys) || !edit_mode) tmo_q <= CNT_W'(HOLD_CYC - 1);
    else if (tmo_q != '0) tmo_q <= tmo_q - 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_b || (|rise.digit) || !(|keys.digit) || rpt_q == '0) rpt_q <= CNT_W'(RPT_CYC - 1);
    else rpt_q <= rpt_q - 1'b1;
  end

  assign rpt_fire = (rpt_q == '0) & (|keys.digit);

  for (genvar i = 0; i < 4; i++) begin : g_dig
    // Lock refuses every digit change
    assign inc[i] = edit_mode & unlocked & (rise.digit[i] | (keys.digit[i] & rpt_fire));
    assign edit_inc[4*i+:4] = !inc[i] ? edit_q[4*i+:4]
                            : (edit_q[4*i+:4] == DIG_MAX) ? 4'h0 : edit_q[4*i+:4] + 4'h1;
  end

  // ==========================================================
  // Mode sequencer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q    <= KP_NORMAL;
      sel_q   <= 1'b0;
      dirty_q <= 1'b0;
      edit_q  <= '0;
    end else if (do_reset) begin
      st_q    <= KP_NORMAL;
      dirty_q <= 1'b0;
    end else if (tout_entry) begin
      st_q    <= KP_TOUT;
      sel_q   <= ~keys.p1;
      edit_q  <= tout_sto_q[~keys.p1];
      dirty_q <= 1'b0;
    end else begin
      case (st_q)
        KP_NORMAL: begin
          if (rise.p1 || (DUAL && rise.p2)) begin
            st_q    <= KP_PRESET;
            sel_q   <= ~rise.p1;
            edit_q  <= preset_q[~rise.p1];
            dirty_q <= 1'b0;
          end else if (keys.digit[3] && keys.digit[2] && !keys.enter
                       && (rise.digit[3] || rise.digit[2])) begin
            st_q <= KP_SELFTEST;
          end
        end
        KP_PRESET, KP_TOUT: begin
          if (rise.enter) begin
            st_q <= KP_NORMAL;
          end else if (tmo_q == '0) begin
            st_q <= KP_NORMAL;
          end else if (|inc) begin
            edit_q  <= edit_inc;
            dirty_q <= 1'b1;
          end
        end
        KP_SELFTEST: begin
          if (rise.enter) st_q <= KP_NORMAL;
        end
        default: st_q <= KP_NORMAL;
      endcase
    end
  end

  // ==========================================================
  // Stored and applied values per channel
  for (genvar c = 0; c < 2; c++) begin : g_ch
    always_ff @(posedge clk) begin
      if (!rst_b) preset_q[c] <= PRESET_RST[c];
      else if (store_ok && st_q == KP_PRESET && sel_q == 1'(c)) preset_q[c] <= edit_q;
    end

    always_ff @(posedge clk) begin
      if (!rst_b) tout_sto_q[c] <= TOUT_RST;
      else if (store_ok && st_q == KP_TOUT && sel_q == 1'(c)) tout_sto_q[c] <= edit_q;
    end

    // A running pulse keeps its old length; the new one is taken after it
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        tout_q[c] <= TOUT_RST;
        pend_q[c] <= 1'b0;
      end else if (store_ok && st_q == KP_TOUT && sel_q == 1'(c)) begin
        if (out_active[c]) begin
          pend_q[c] <= 1'b1;
        end else begin
          tout_q[c] <= edit_q;
          pend_q[c] <= 1'b0;
        end
      end else if (pend_q[c] && !out_active[c]) begin
        tout_q[c] <= tout_sto_q[c];
        pend_q[c] <= 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_b || st_q != KP_SELFTEST || do_reset) test_q[c] <= 1'b0;
      else if (unlocked && (c == 0 ? rise.p1 : (DUAL && rise.p2))) test_q[c] <= ~test_q[c];
    end

    tout_apply_a: assert property (pend_q[c] && !out_active[c] |=> tout_q[c] == tout_sto_q[c])
      else $error("pending duration not applied after pulse");
    tout_range_a: assert property (tout_sto_q[c] != TOUT_ZERO)
      else $error("stored duration is zero");
  end

  // ==========================================================
  // Scrolling
  always_ff @(posedge clk) begin
    if (!rst_b) scrl_q <= 1'b0;
    else if (st_q == KP_NORMAL && keys.enter && rise.digit[3]) scrl_q <= ~scrl_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_b || !scrl_q || do_reset) begin
      scrl_idx_q <= '0;
      scrl_cnt_q <= CNT_W'(SCRL_CYC - 1);
    end else if (scrl_cnt_q != '0) begin
      scrl_cnt_q <= scrl_cnt_q - 1'b1;
    end else begin
      scrl_cnt_q <= CNT_W'(SCRL_CYC - 1);
      if (scrl_idx_q == 3'(SCRL_LAST)) scrl_idx_q <= '0;
      else if (scrl_idx_q == 3'd1 && !DUAL) scrl_idx_q <= 3'(SCRL_LAST);
      else scrl_idx_q <= scrl_idx_q + 3'd1;
    end
  end

  // ==========================================================
  // Display
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      disp_value_q <= '0;
      disp_label_q <= LBL_NONE;
    end else begin
      disp_label_q <= LBL_NONE;
      disp_value_q <= run_time;
      case (st_q)
        KP_PRESET, KP_TOUT: disp_value_q <= edit_q;
        KP_SELFTEST:        disp_value_q <= ST_PATTERN;
        KP_NORMAL: begin
          if (scrl_q) begin
            case (scrl_idx_q)
              3'd0: disp_label_q <= LBL_P1;
              3'd1: disp_value_q <= preset_q[0];
              3'd2: disp_label_q <= LBL_P2;
              3'd3: disp_value_q <= preset_q[1];
              default: disp_value_q <= run_time;
            endcase
          end
        end
        default: disp_value_q <= run_time;
      endcase
    end
  end

  // ==========================================================
  // Timer side strobes and nonvolatile write
  // Editing never gates these, so the timer keeps running throughout
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timer_reset_q <= 1'b0;
      outputs_off_q <= 1'b0;
    end else begin
      timer_reset_q <= do_reset;
      outputs_off_q <= do_reset;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) nv_q <= '0;
    else nv_q <= '{wr: store_ok, ch: sel_q, kind: st_q == KP_TOUT, data: edit_q};
  end

  assign timer_reset     = timer_reset_q;
  assign timer_to_preset = ctrl_rtp_q;
  assign outputs_off     = outputs_off_q;
  assign preset_val      = preset_q;
  assign tout_val        = tout_q;
  assign disp_value      = disp_value_q;
  assign disp_label      = disp_label_q;
  assign nv_write        = nv_q;
  assign test_out        = test_q;

  // ==========================================================
  // Register access
  kp_axil u_axil (
    .clk     (clk),
    .rst_b   (rst_b),
    .axi_req (axi_req),
    .axi_rsp (axi_rsp),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // Only the control word is writable; other writes answer SLVERR
  assign wr_ok = wr_addr == REG_CTRL;

  always_ff @(posedge clk) begin
    if (!rst_b) ctrl_rtp_q <= CTRL_RST;
    else if (wr_en && wr_ok && wr_strb[0]) ctrl_rtp_q <= wr_data[CTRL_RTP_BIT];
  end

  always_comb begin
    rd_data = '0;
    rd_ok   = 1'b1;
    case (rd_addr)
      REG_CTRL:  rd_data[CTRL_RTP_BIT] = ctrl_rtp_q;
      REG_STAT: begin
        rd_data[STAT_ST_LSB+:2] = st_q;
        rd_data[STAT_SCRL]      = scrl_q;
        rd_data[STAT_DIRTY]     = dirty_q;
        rd_data[STAT_PEND+:2]   = pend_q;
        rd_data[STAT_ACT+:2]    = out_active;
      end
      REG_PRE1:  rd_data[VAL_W-1:0] = preset_q[0];
      REG_PRE2:  rd_data[VAL_W-1:0] = preset_q[1];
      REG_TOUT1: rd_data[VAL_W-1:0] = tout_sto_q[0];
      REG_TOUT2: rd_data[VAL_W-1:0] = tout_sto_q[1];
      default:   rd_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // Checks
  sequence s_rst_press;
    rise.reset && reset_enable_switch && !keys.p1 && !p2_ok;
  endsequence

  sequence s_edit_exit;
    edit_mode && rise.enter && !rise.reset;
  endsequence

  rst_clear_a: assert property (s_rst_press |=> timer_reset_q && outputs_off_q && st_q == KP_NORMAL ##1 !timer_reset_q)
    else $error("reset key did not clear");
  rst_ignore_a: assert property (rise.reset && !reset_enable_switch |=> !timer_reset_q)
    else $error("reset key acted while disabled");
  preset_show_a: assert property (st_q == KP_NORMAL && rise.p1 && !keys.reset |=> st_q == KP_PRESET && !sel_q ##1 disp_value_q == preset_q[0])
    else $error("preset key did not show preset");
  store_now_a: assert property (store_ok && st_q == KP_PRESET |=> preset_q[$past(sel_q)] == $past(edit_q) && nv_q.wr)
    else $error("preset not stored on enter");
  st_exit_a: assert property (st_q == KP_SELFTEST && rise.enter |=> st_q == KP_NORMAL ##1 test_q == '0)
    else $error("enter did not end self-test");
  scroll_flip_a: assert property (st_q == KP_NORMAL && keys.enter && rise.digit[3] |=> scrl_q != $past(scrl_q))
    else $error("scroll did not toggle");
  scroll_skip_a: assert property (scrl_q && scrl_idx_q == 3'd1 && scrl_cnt_q == '0 && !do_reset |=> scrl_idx_q == (DUAL ? 3'd2 : 3'(SCRL_LAST)))
    else $error("scroll sequence wrong");
  factory_val_a: assert property (!$past(rst_b) |-> preset_q == PRESET_RST && tout_sto_q == {2{TOUT_RST}})
    else $error("factory values wrong after reset");
  exit_keep_a: assert property (s_edit_exit and (!dirty_q) |=> st_q == KP_NORMAL && $stable(preset_q) && $stable(tout_sto_q))
    else $error("unchanged enter altered values");
  digit_wrap_a: assert property (inc[0] && edit_q[3:0] == DIG_MAX && !rise.enter && tmo_q != '0 && !rst_press |=> edit_q[3:0] == 4'h0)
    else $error("digit did not wrap");
  edit_tmo_a: assert property (edit_mode && tmo_q == '0 && !rise.enter && !rise.reset |=> st_q == KP_NORMAL && $stable(preset_q) && $stable(tout_sto_q))
    else $error("timeout did not discard edit");
  lock_hold_a: assert property (!program_lock_input_b |=> $stable(preset_q) && $stable(tout_sto_q) && !$rose(test_q[0]))
    else $error("value changed while locked");
endmodule : kp_panel

// ### verification/kp_operator.sv
/*
  Operator model: presses front panel keys and sets the rear switches.
  Assumes the bench calls its tasks from one process, right after an edge.
*/
module kp_operator (
  input  wire logic        clk,
  output kp_pkg::kp_keys_s keys,
  output logic             reset_enable_switch,
  output logic             program_lock_input_b
);
  import kp_pkg::*;
  // ==========================================
  // Keys
  initial begin
    keys = '0;
    reset_enable_switch = 1'b1;
    program_lock_input_b = 1'b1;
  end
  task automatic set(input logic [7:0] k);
    @(posedge clk);
    keys <= kp_keys_s'(k);
  endtask : set
  // Held 4 cycles, well below the repeat time, so one step only
  task automatic push(input logic [7:0] k, input logic [7:0] b = 8'h00);
    set(k | b);
    repeat (3) @(posedge clk);
    set(b);
    repeat (3) @(posedge clk);
  endtask : push
endmodule : kp_operator

// ### verification/kp_panel_bench.sv
/*
  Bench of the keypad programmer: AXI4-Lite tasks and operator key strokes.
  Assumes kp_operator and shortened hold and repeat counts.
*/
`define CK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module kp_panel_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import kp_pkg::*;
  // ==========================================
  // Setup
  localparam logic [7:0] ENT = 8'h01, P2K = 8'h02, P1K = 8'h04, RST = 8'h08;
  localparam logic [7:0] D0 = 8'h10, D1 = 8'h20, D3 = 8'h80;
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  kp_axi_req_s      q = '0;
  kp_axi_rsp_s      s;
  kp_keys_s         keys;
  logic             sw, lock_b, trst, toff, to_pre;
  logic [1:0]       oa = 2'b00;
  logic [1:0][15:0] pre, tou;
  logic [15:0]      disp;
  logic [15:0]      rt = 16'h1234;
  kp_label_e        lbl;
  kp_nv_s           nv;
  logic [1:0]       tst;
  logic [31:0]      d;
  logic [1:0]       r;
  int n_errors = 0, tests_run = 0, n_rst = 0, n_off = 0, n_nv = 0, n_a = 0, n_b = 0;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    n_rst <= n_rst + int'(trst === 1'b1);
    n_off <= n_off + int'(toff === 1'b1);
    n_nv <= n_nv + int'(nv.wr === 1'b1);
  end
  kp_operator op_u (.clk(clk), .keys(keys), .reset_enable_switch(sw), .program_lock_input_b(lock_b));
  kp_panel #(.HOLD_CYC(200), .RPT_CYC(20), .SCRL_CYC(10)) dut_u (.clk(clk), .rst_b(rst_b),
    .axi_req(q), .axi_rsp(s), .keys(keys), .reset_enable_switch(sw), .program_lock_input_b(lock_b),
    .run_time(rt), .out_active(oa), .timer_reset(trst), .timer_to_preset(to_pre),
    .outputs_off(toff), .preset_val(pre), .tout_val(tou), .disp_value(disp), .disp_label(lbl),
    .nv_write(nv), .test_out(tst));
  task automatic results;
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  // ==========================================
  // Bus tasks: sample 1 ns after the edge, act on the next edge
  task automatic rd(input logic [7:0] a);
    logic ak, rv;
    @(posedge clk);
    q.arvalid <= 1'b1;
    q.araddr <= a;
    q.rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      #1;
      ak = s.arready;
      rv = s.rvalid;
      d = s.rdata;
      r = s.rresp;
      @(posedge clk);
      if (ak)
        q.arvalid <= 1'b0;
      if (rv) begin
        q.rready <= 1'b0;
        return;
      end
    end
    n_errors++;
    results;
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    @(posedge clk);
    q.awvalid <= 1'b1;
    q.awaddr <= a;
    q.wvalid <= 1'b1;
    q.wdata <= v;
    q.wstrb <= 4'hf;
    q.bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      #1;
      aw = s.awready;
      w = s.wready;
      b = s.bvalid;
      r = s.bresp;
      @(posedge clk);
      if (aw)
        q.awvalid <= 1'b0;
      if (w)
        q.wvalid <= 1'b0;
      if (b) begin
        q.bready <= 1'b0;
        return;
      end
    end
    n_errors++;
    results;
  endtask : wr
  // ==========================================
  // Sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(REG_PRE1);
    `CK(d[15:0], 16'h0500)
    rd(REG_PRE2);
    `CK(d[15:0], 16'h1000)
    rd(REG_TOUT1);
    `CK(d[15:0], 16'h0010)
    rd(8'h40);
    `CK(r, RESP_SLVERR)
    wr(REG_CTRL, 32'h1);
    `CK(to_pre, 1'b1)
    op_u.reset_enable_switch <= 1'b0;
    op_u.push(RST);
    `CK(n_rst, 0)
    op_u.reset_enable_switch <= 1'b1;
    op_u.push(RST);
    `CK(n_rst, 1)
    `CK(n_off, 1)
    op_u.push(P1K);
    `CK(disp, 16'h0500)
    repeat (10) op_u.push(D0);
    `CK(disp, 16'h0500)
    op_u.push(D0);
    op_u.push(ENT);
    `CK(pre[0], 16'h0501)
    op_u.push(P2K);
    op_u.push(ENT);
    `CK(pre[1], 16'h1000)
    `CK(n_nv, 1)
    op_u.program_lock_input_b <= 1'b0;
    op_u.push(P1K);
    op_u.push(D0);
    op_u.push(ENT);
    `CK(pre[0], 16'h0501)
    `CK(n_nv, 1)
    op_u.program_lock_input_b <= 1'b1;
    op_u.push(P1K);
    op_u.push(D0);
    repeat (250) @(posedge clk);
    rd(REG_STAT);
    `CK(d[1:0], 2'd0)
    `CK(pre[0], 16'h0501)
    op_u.push(P1K);
    rt <= 16'h0042;
    op_u.push(RST);
    `CK(n_rst, 2)
    `CK(disp, rt)
    op_u.reset_enable_switch <= 1'b0;
    op_u.set(P1K);
    op_u.push(RST, P1K);
    op_u.set(8'h00);
    rd(REG_STAT);
    `CK(d[1:0], 2'd1)
    op_u.reset_enable_switch <= 1'b1;
    op_u.push(ENT);
    op_u.set(P1K);
    op_u.push(RST, P1K);
    op_u.set(8'h00);
    rd(REG_STAT);
    `CK(d[1:0], 2'd2)
    `CK(n_rst, 2)
    op_u.push(D1);
    oa <= 2'b01;
    op_u.push(ENT);
    `CK(tou[0], 16'h0010)
    `CK(n_nv, 2)
    oa <= 2'b00;
    repeat (3) @(posedge clk);
    `CK(tou[0], 16'h0020)
    op_u.set(ENT);
    op_u.push(D3, ENT);
    op_u.set(8'h00);
    rd(REG_STAT);
    `CK(d[2], 1'b1)
    // One full scroll period: each of the five steps stands for ten cycles
    repeat (50) begin
      @(posedge clk);
      n_a += int'(lbl == LBL_P2);
      n_b += int'(disp == 16'h1000);
    end
    `CK(n_a, 10)
    `CK(n_b, 10)
    op_u.push(8'hc0);
    op_u.push(P1K);
    `CK(tst, 2'b01)
    op_u.program_lock_input_b <= 1'b0;
    op_u.push(P1K);
    `CK(tst, 2'b01)
    op_u.program_lock_input_b <= 1'b1;
    op_u.push(ENT);
    `CK(tst, 2'b00)
    rd(REG_STAT);
    `CK(d[1:0], 2'd0)
    results;
  end
endmodule : kp_panel_bench
